// ===== csds_pkg.sv
// Purpose: Shared constants and types for the core store drive select block
// Assumes: Storage clock phases are generated inside the block from mclk
// Notes:   Cycle phase counts are in mclk cycles at 10 MHz
package csds_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Phase times of one storage half cycle, in ns
  localparam int unsigned T_DRIVE_ON_NS   = 200;
  localparam int unsigned T_STROBE_NS     = 500;
  localparam int unsigned T_DRIVE_OFF_NS  = 700;
  localparam int unsigned T_DONE_NS       = 900;
  localparam logic [3:0]  CYC_DRIVE_ON    = 4'((T_DRIVE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  CYC_STROBE      = 4'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  CYC_DRIVE_OFF   = 4'(T_DRIVE_OFF_NS / CLK_PERIOD_NS);
  localparam logic [3:0]  CYC_DONE        = 4'(T_DONE_NS / CLK_PERIOD_NS);
  // Configuration codes
  localparam logic [1:0]  CFG_8K          = 2'h0;
  localparam logic [1:0]  CFG_16K         = 2'h1;
  localparam logic [1:0]  CFG_32K         = 2'h2;
  // Address field positions (bit 0 is the high-order bit, as printed)
  localparam int unsigned HB1 = 1;
  localparam int unsigned HB2 = 2;
  localparam int unsigned HB3 = 3;
  localparam int unsigned HB4 = 4;
  localparam int unsigned HB5 = 5;
  localparam int unsigned HB6 = 6;
  localparam int unsigned LB2 = 2;
  localparam int unsigned LB3 = 3;
  localparam int unsigned LB4 = 4;
  localparam int unsigned LB5 = 5;
  localparam int unsigned LB7 = 7;
  localparam logic [8:0]  DATA_RESET      = 9'h000;
  typedef enum logic [2:0] {
    CSDS_IDLE  = 3'b000,
    CSDS_READ  = 3'b001,
    CSDS_HOLD  = 3'b011,
    CSDS_WRITE = 3'b010
  } csds_state_t;
endpackage : csds_pkg

// ===== csds_timing_if.sv
// Purpose: Carries cycle flags and phase count to the phase unit, and its drive and strobe windows back to the sequencer
// Assumes: Single mclk domain
// Notes:   Phases are levels for the duration of each window
`timescale 1ns/100ps
interface csds_timing_if;
  logic       rd_cycle;
  logic       wr_cycle;
  logic       drive_win;
  logic       strobe;
  logic [3:0] phase_cnt;
  modport seq   (output rd_cycle, output wr_cycle, input drive_win, input strobe, output phase_cnt);
  modport phase (input rd_cycle, input wr_cycle, output drive_win, output strobe, input phase_cnt);
endinterface : csds_timing_if

// ===== csds_phase.sv
// Purpose: Derives drive and strobe windows from the cycle phase count
// Assumes: phase_cnt restarts at zero on each half cycle
// Notes:   Outputs are registered to keep drive edges glitch free
`timescale 1ns/100ps
module csds_phase (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_n,
  // Sequencer side
  csds_timing_if.phase tif
);
  wire active = tif.rd_cycle | tif.wr_cycle;
  wire win    = active && (tif.phase_cnt >= csds_pkg::CYC_DRIVE_ON) && (tif.phase_cnt < csds_pkg::CYC_DRIVE_OFF);
  wire stb    = tif.rd_cycle && (tif.phase_cnt == csds_pkg::CYC_STROBE);
  logic drive_win_reg;
  logic strobe_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_win_reg <= 1'b0;
      strobe_reg    <= 1'b0;
    end else begin
      drive_win_reg <= win;
      strobe_reg    <= stb;
    end
  end
  assign tif.drive_win = drive_win_reg;
  assign tif.strobe    = strobe_reg;
endmodule : csds_phase

// ===== csds_drive_select.sv
// Purpose: Drive line, sense gate and inhibit selection for a core store
// Assumes: Caller holds address steady from read call until write ends
// Notes:   Address bit 0 is the high-order bit of each byte register
`timescale 1ns/100ps
module csds_drive_select (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Processor interface
  input  wire logic [7:0]  addr_hi,
  input  wire logic [7:0]  addr_lo,
  input  wire logic [8:0]  store_bits,
  input  wire logic        read_call,
  input  wire logic        write_call,
  input  wire logic        unit_sel,
  input  wire logic        use_aux,
  input  wire logic [1:0]  cfg_size,
  output logic             data_ready,
  output logic [8:0]       read_data,
  output logic             cycle_busy,
  // Sense amplifiers
  input  wire logic [8:0]  sense_in,
  // Y drive
  output logic             y_read_drivers,
  output logic             y_write_drivers,
  output logic             y_read_source,
  output logic             y_write_source,
  output logic             y_src_switch,
  output logic             y_sink_switch,
  output logic [3:0]       y_bump_drivers,
  // X drive
  output logic [3:0]       x_read_drivers,
  output logic [3:0]       x_write_drivers,
  output logic [3:0]       x_read_source,
  output logic [3:0]       x_write_source,
  output logic             x_src_switch,
  output logic             x_sink_switch,
  // Sense and inhibit
  output logic [3:0]       sense_group_gate,
  output logic             sense_capture_pulse,
  output logic [3:0]       inhibit_set_gate,
  output logic [8:0]       inhibit_drive
);
  // Pin inputs pass two flops before use
  logic [7:0] ahi_s1, ahi_reg, alo_s1, alo_reg;
  logic [8:0] st_s1, st_reg, sn_s1, sn_reg;
  logic [4:0] ctl_s1, ctl_reg;
  logic [1:0] cfg_s1, cfg_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ahi_s1 <= 8'h00; ahi_reg <= 8'h00; alo_s1 <= 8'h00; alo_reg <= 8'h00;
      st_s1  <= 9'h000; st_reg <= 9'h000; sn_s1 <= 9'h000; sn_reg <= 9'h000;
      ctl_s1 <= 5'h00; ctl_reg <= 5'h00; cfg_s1 <= 2'h0; cfg_reg <= 2'h0;
    end else begin
      ahi_s1 <= addr_hi;    ahi_reg <= ahi_s1;
      alo_s1 <= addr_lo;    alo_reg <= alo_s1;
      st_s1  <= store_bits; st_reg  <= st_s1;
      sn_s1  <= sense_in;   sn_reg  <= sn_s1;
      ctl_s1 <= {read_call, write_call, unit_sel, use_aux, 1'b0};
      ctl_reg <= ctl_s1;
      cfg_s1 <= cfg_size;   cfg_reg <= cfg_s1;
    end
  end
  // Bit 0 of the printed numbering is the MSB
  function automatic logic hb(input logic [7:0] v, input int unsigned i);
    hb = v[7 - i];
  endfunction : hb

  wire rd_req  = ctl_reg[4];
  wire wr_req  = ctl_reg[3];
  wire go      = ctl_reg[2];
  wire aux     = ctl_reg[1];
  logic rd_req_d, wr_req_d;
  wire rd_rise = rd_req & ~rd_req_d;
  wire wr_rise = wr_req & ~wr_req_d;

  csds_timing_if tif ();
  csds_phase u_phase (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  csds_pkg::csds_state_t state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic        write_set_reg;
  wire         done = (cnt_reg == csds_pkg::CYC_DONE);

  always_comb begin
    state_next = state_reg;
    cnt_next   = (state_reg == csds_pkg::CSDS_READ || state_reg == csds_pkg::CSDS_WRITE) ? cnt_reg + 4'h1 : 4'h0;
    case (state_reg)
      csds_pkg::CSDS_IDLE: begin
        if (rd_rise) begin
          state_next = csds_pkg::CSDS_READ;
          cnt_next   = 4'h0;
        end
      end
      csds_pkg::CSDS_READ: begin
        if (done) begin
          state_next = csds_pkg::CSDS_HOLD;
        end
      end
      csds_pkg::CSDS_HOLD: begin
        if (wr_rise && go) begin
          state_next = csds_pkg::CSDS_WRITE;
          cnt_next   = 4'h0;
        end
      end
      csds_pkg::CSDS_WRITE: begin
        if (done) begin
          state_next = csds_pkg::CSDS_IDLE;
        end
      end
      default: state_next = csds_pkg::CSDS_IDLE;
    endcase
  end
  // Read calls while holding are refused so the position is restored first

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= csds_pkg::CSDS_IDLE;
      cnt_reg       <= 4'h0;
      rd_req_d      <= 1'b0;
      wr_req_d      <= 1'b0;
      write_set_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      rd_req_d      <= rd_req;
      wr_req_d      <= wr_req;
      write_set_reg <= (state_next == csds_pkg::CSDS_WRITE);
    end
  end
  assign tif.rd_cycle  = (state_reg == csds_pkg::CSDS_READ);
  assign tif.wr_cycle  = (state_reg == csds_pkg::CSDS_WRITE);
  assign tif.phase_cnt = cnt_reg;

  // Address decode, same address on both halves
  wire h1 = hb(ahi_reg, csds_pkg::HB1);
  wire h2 = hb(ahi_reg, csds_pkg::HB2);
  wire h3 = hb(ahi_reg, csds_pkg::HB3);
  wire h4 = hb(ahi_reg, csds_pkg::HB4);
  wire h5 = hb(ahi_reg, csds_pkg::HB5);
  wire h6 = hb(ahi_reg, csds_pkg::HB6);
  wire l2 = hb(alo_reg, csds_pkg::LB2);
  wire l3 = hb(alo_reg, csds_pkg::LB3);
  wire l4 = hb(alo_reg, csds_pkg::LB4);
  wire l5 = hb(alo_reg, csds_pkg::LB5);
  wire l7 = hb(alo_reg, csds_pkg::LB7);
  wire rd_win = tif.rd_cycle & tif.drive_win;
  wire wr_win = write_set_reg & tif.drive_win;
  wire is16 = (cfg_reg == csds_pkg::CFG_16K);
  wire is32 = (cfg_reg == csds_pkg::CFG_32K);
  // 8K unit only answers in its own block; 16K unit when bit 1 is low, 32K unit always
  wire blk_ok = is32 | (is16 & ~h1) | (~h1 & ~h2);
  // X set index: 16K set from bit 1, 8K half from bit 2
  wire [1:0] xsel = {h1 & is32, h2};
  wire [3:0] xdec = 4'(1) << xsel;
  wire [1:0] grp  = {h1, h2};
  wire [3:0] gdec = 4'(1) << grp;

  logic [3:0] xrd_d, xwr_d, xrs_d, xws_d, sg_d, ih_d, bump_d;
  logic [8:0] inh_d;
  always_comb begin
    xrd_d  = (rd_win & blk_ok) ? xdec : 4'h0;
    xwr_d  = (wr_win & blk_ok) ? xdec : 4'h0;
    // Source direction flips with half: read on first half uses read source
    xrs_d  = (rd_win & go & blk_ok) ? xdec : 4'h0;
    xws_d  = (wr_win & blk_ok) ? xdec : 4'h0;
    sg_d   = (tif.rd_cycle & blk_ok & ~l7) ? gdec : 4'h0;
    ih_d   = (wr_win & blk_ok & ~l7) ? gdec : 4'h0;
    inh_d  = (wr_win & blk_ok & ~l7) ? ~st_reg : 9'h000;
    bump_d = ((rd_win | wr_win) & aux & h3) ? xdec : 4'h0;
  end

  logic [8:0] latch_reg;
  logic       ready_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= csds_pkg::DATA_RESET;
      ready_reg <= 1'b0;
    end else begin
      if (rd_rise && state_reg == csds_pkg::CSDS_IDLE) begin
        latch_reg <= csds_pkg::DATA_RESET;
      end else if (tif.strobe && |sg_d) begin
        latch_reg <= latch_reg | sn_reg;
      end
      ready_reg <= tif.rd_cycle & done & go;
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      y_read_drivers <= 1'b0; y_write_drivers <= 1'b0;
      y_read_source  <= 1'b0; y_write_source  <= 1'b0;
      y_src_switch   <= 1'b0; y_sink_switch   <= 1'b0;
      y_bump_drivers <= 4'h0;
      x_read_drivers <= 4'h0; x_write_drivers <= 4'h0;
      x_read_source  <= 4'h0; x_write_source  <= 4'h0;
      x_src_switch   <= 1'b0; x_sink_switch   <= 1'b0;
      sense_group_gate <= 4'h0; sense_capture_pulse <= 1'b0;
      inhibit_set_gate <= 4'h0; inhibit_drive <= 9'h000;
      data_ready <= 1'b0; read_data <= 9'h000; cycle_busy <= 1'b0;
    end else begin
      y_read_drivers  <= rd_win & ~aux;
      y_write_drivers <= wr_win & ~aux;
      y_read_source   <= rd_win & go;
      y_write_source  <= wr_win & go;
      y_src_switch    <= (rd_win | wr_win) & ~aux & ~h3 & ~h4 & ~h5 & h6;
      y_sink_switch   <= (rd_win | wr_win) & ~h3 & ~h4 & ~h5 & h6;
      y_bump_drivers  <= bump_d;
      x_read_drivers  <= xrd_d;
      x_write_drivers <= xwr_d;
      x_read_source   <= xrs_d;
      x_write_source  <= xws_d;
      x_src_switch    <= (|xrd_d | |xwr_d) & ~l5 & ~l7;
      x_sink_switch   <= (|xrd_d | |xwr_d) & l3 & ~l2 & ~l4;
      sense_group_gate    <= sg_d;
      sense_capture_pulse <= tif.strobe & |sg_d;
      inhibit_set_gate    <= ih_d;
      inhibit_drive       <= inh_d;
      data_ready <= ready_reg;
      read_data  <= latch_reg;
      // Cores end the read at zero; stored only by the write
      cycle_busy <= (state_reg != csds_pkg::CSDS_IDLE);
    end
  end
endmodule : csds_drive_select

// ===== csds_drive_select_chk.sv
// Purpose: Port assertions for csds_drive_select
// Assumes: One mclk domain, async active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/100ps
module csds_drive_select_chk (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Observed outputs
  input wire logic       data_ready,
  input wire logic       sense_capture_pulse,
  input wire logic [3:0] sense_group_gate,
  input wire logic [3:0] inhibit_set_gate,
  input wire logic [8:0] inhibit_drive,
  input wire logic [3:0] x_read_drivers,
  input wire logic [3:0] x_write_drivers,
  input wire logic       y_read_source,
  input wire logic       y_write_source
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_dr; data_ready ##1 !data_ready; endsequence
  sequence s_cap; sense_capture_pulse ##1 !sense_capture_pulse; endsequence
  property p_sense_one; $onehot0(sense_group_gate); endproperty
  property p_inh_one; $onehot0(inhibit_set_gate); endproperty
  property p_inh_gated; |inhibit_drive |-> |inhibit_set_gate; endproperty
  property p_x_dir; !(|x_read_drivers && |x_write_drivers); endproperty
  property p_x_one; $onehot0(x_read_drivers) && $onehot0(x_write_drivers); endproperty
  property p_y_dir; !(y_read_source && y_write_source); endproperty
  property p_ready; $rose(data_ready) |-> s_dr; endproperty
  property p_cap; $rose(sense_capture_pulse) |-> s_cap; endproperty
  a_sense_one: assert property (p_sense_one) else $error("two sense groups");
  a_inh_one: assert property (p_inh_one) else $error("two inhibit sets");
  a_inh_gated: assert property (p_inh_gated) else $error("inhibit without set");
  a_x_dir: assert property (p_x_dir) else $error("both x directions");
  a_x_one: assert property (p_x_one) else $error("two x driver sets");
  a_y_dir: assert property (p_y_dir) else $error("both y sources");
  a_ready: assert property (p_ready) else $error("ready not a pulse");
  a_cap: assert property (p_cap) else $error("strobe not a pulse");
endmodule : csds_drive_select_chk

bind csds_drive_select csds_drive_select_chk chk (.mclk, .rst_n, .data_ready, .sense_capture_pulse,
  .sense_group_gate, .inhibit_set_gate, .inhibit_drive, .x_read_drivers, .x_write_drivers,
  .y_read_source, .y_write_source);

// ===== csds_cpu_model.sv
// Purpose: Processor model issuing read and write calls
// Assumes: Calls are levels raised 5 ns after mclk rises
// Notes:   Address held from read until the next read
`timescale 1ns/100ps
module csds_cpu_model (
  // Clock
  input  wire logic  mclk,
  // Storage answer
  input  wire logic  data_ready,
  // Calls, address and store lines
  output logic [7:0] addr_hi,
  output logic [7:0] addr_lo,
  output logic [8:0] store_bits,
  output logic       read_call,
  output logic       write_call
);
  initial begin
    {addr_hi, addr_lo, store_bits, read_call, write_call} = '0;
  end
  task automatic rd(input logic [15:0] a, output logic ok);
    int n;
    @(posedge mclk);
    #5;
    {addr_hi, addr_lo} = a;
    read_call = 1'b1;
    ok = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge mclk);
      #5;
      ok = (data_ready === 1'b1);
    end
    read_call = 1'b0;
  endtask : rd
  task automatic wr(input logic [8:0] d);
    @(posedge mclk);
    #5;
    store_bits = d;
    write_call = 1'b1;
    repeat (3) @(posedge mclk);
    #5;
    write_call = 1'b0;
  endtask : wr
endmodule : csds_cpu_model

// ===== tb_csds_drive_select.sv
// Purpose: Self-checking bench for csds_drive_select
// Assumes: 10 MHz mclk, inputs change 5 ns after rising edge
// Notes:   Reference keeps core contents in an array
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_csds_drive_select;
  logic        mclk, rst_n, unit_sel, use_aux, read_call, write_call, data_ready, cycle_busy;
  logic        y_write_drivers, y_sink_switch, x_src_switch, x_sink_switch, ok, rd_on;
  logic [1:0]  cfg_size;
  logic [3:0]  y_bump_drivers, x_read_drivers, x_write_drivers, sense_group_gate, inhibit_set_gate;
  logic [7:0]  addr_hi, addr_lo;
  logic [8:0]  store_bits, sense_in, read_data, inhibit_drive, cur, inh;
  logic [3:0]  xr, xw, sg, ig, bp;
  logic        ys, xs, xk, yw;
  logic [15:0] a;
  logic [31:0] seed;
  logic [8:0]  mem [int];
  int          fails, n_checks, k;
  csds_drive_select dut (.mclk, .rst_n, .addr_hi, .addr_lo, .store_bits, .read_call, .write_call,
    .unit_sel, .use_aux, .cfg_size, .data_ready, .read_data, .cycle_busy, .sense_in,
    .y_read_drivers(), .y_write_drivers, .y_read_source(), .y_write_source(), .y_src_switch(),
    .y_sink_switch, .y_bump_drivers, .x_read_drivers, .x_write_drivers, .x_read_source(),
    .x_write_source(), .x_src_switch, .x_sink_switch, .sense_group_gate, .sense_capture_pulse(),
    .inhibit_set_gate, .inhibit_drive);
  csds_cpu_model cpu (.mclk, .data_ready, .addr_hi, .addr_lo, .store_bits, .read_call, .write_call);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  always #50 mclk = ~mclk;
  // Cores answer only while read; otherwise a changing pattern
  always @(posedge mclk) #5 sense_in = rd_on ? cur : ~sense_in;
  always @(posedge mclk) begin
    #1;
    xr |= x_read_drivers; xw |= x_write_drivers; sg |= sense_group_gate;
    ig |= inhibit_set_gate; bp |= y_bump_drivers; inh |= inhibit_drive;
    ys |= y_sink_switch; xs |= x_src_switch; xk |= x_sink_switch; yw |= y_write_drivers;
  end
  task automatic clr();
    {xr, xw, sg, ig, bp, inh, ys, xs, xk, yw} = '0;
  endtask : clr
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic op(input int i);
    logic [1:0] b;
    logic [8:0] d;
    seed = nx(seed);
    cfg_size = 2'(i % 3);
    use_aux = (i == 5);
    b = seed[1:0] & {cfg_size == csds_pkg::CFG_32K, cfg_size != csds_pkg::CFG_8K};
    a = {1'b0, b, seed[12:8], seed[20:14], 1'b0};
    if (i % 2 == 0) a[12:9] = 4'b0001;
    if (i % 2 == 0) a[5:2] = 4'b0100;
    d = seed[30:22];
    cur = mem.exists(a) ? mem[a] : 9'h000;
    clr();
    rd_on = 1'b1;
    cpu.rd(a, ok);
    `CHK(ok, 1'b1)
    if (ok !== 1'b1) finish_test();
    `CHK(read_data, cur)
    `CHK(sg, 4'h1 << b)
    `CHK(xr, 4'h1 << b)
    `CHK(ys, a[12:9] == 4'b0001)
    `CHK(xs, !a[2] && !a[0])
    `CHK(xk, a[4] && !a[5] && !a[3])
    mem[a] = 9'h000;
    rd_on = 1'b0;
    if (i == 1) begin
      clr();
      unit_sel = 1'b0;
      cpu.wr(d);
      repeat (20) @(posedge mclk);
      `CHK(xw, 4'h0)
      unit_sel = 1'b1;
    end
    clr();
    cpu.wr(d);
    repeat (6) @(posedge mclk);
    for (k = 0; k < 60 && cycle_busy !== 1'b0; k++) @(posedge mclk);
    if (k == 60) begin
      fails++;
      finish_test();
    end
    `CHK(xw, 4'h1 << b)
    `CHK(ig, 4'h1 << b)
    `CHK(inh, ~d)
    `CHK(yw, !use_aux)
    `CHK(|bp, use_aux && a[12])
    mem[a] = d;
  endtask : op
  initial begin
    {mclk, rst_n, use_aux, rd_on, fails, n_checks} = '0;
    {unit_sel, cfg_size, sense_in, seed} = {1'b1, csds_pkg::CFG_32K, 9'h000, 32'h8C1EC605};
    clr();
    repeat (6) @(posedge mclk);
    #5 rst_n = 1'b1;
    cpu.wr(9'h155);
    repeat (30) @(posedge mclk);
    `CHK(xw, 4'h0)
    for (int i = 0; i < 12; i++) op(i);
    finish_test();
  end
endmodule : tb_csds_drive_select
